// ==== design/rsbw_pkg.sv ====
// Package: constants and types for the timekeeper/SRAM bus write path
package rsbw_pkg;
  localparam logic [6:0] RSBW_CTRL_ADDR  = 7'h6f;
  localparam logic [6:0] RSBW_PROT_ADDR  = 7'h57;
  localparam logic [7:0] RSBW_REG_FIRST  = 8'h00;
  localparam logic [7:0] RSBW_REG_LAST   = 8'h1f;
  localparam logic [7:0] RSBW_SRAM_FIRST = 8'h20;
  localparam logic [7:0] RSBW_SRAM_LAST  = 8'h5f;
  localparam logic [7:0] RSBW_WEEKDAY_CODE_ADDR = 8'h03;
  localparam logic [7:0] RSBW_DN_MIN     = 8'h18;
  localparam logic [7:0] RSBW_DN_HOUR    = 8'h19;
  localparam logic [7:0] RSBW_DN_DATE    = 8'h1a;
  localparam logic [7:0] RSBW_DN_MONTH   = 8'h1b;
  localparam logic [7:0] RSBW_UP_MIN     = 8'h1c;
  localparam logic [7:0] RSBW_UP_HOUR    = 8'h1d;
  localparam logic [7:0] RSBW_UP_DATE    = 8'h1e;
  localparam logic [7:0] RSBW_UP_MONTH   = 8'h1f;
  localparam logic [7:0] RSBW_MIN_MASK   = 8'h7f;
  localparam logic [7:0] RSBW_HOUR_MASK  = 8'h7f;
  localparam logic [7:0] RSBW_DATE_MASK  = 8'h3f;
  localparam logic [7:0] RSBW_MONTH_MASK = 8'hff;
  localparam logic [7:0] RSBW_STAMP_RST  = 8'h00;
  localparam int         RSBW_FLAG_BIT   = 4;
  localparam int         RSBW_VBEN_BIT   = 3;
  localparam int         RSBW_OSC_BIT    = 5;
  localparam logic [7:0] RSBW_WEEKDAY_CODE_MASK = 8'h0f;
  localparam logic [3:0] RSBW_BIT_LAST   = 4'h8;

  typedef enum logic [2:0] {
    RSBW_IDLE = 3'b000,
    RSBW_CTRL = 3'b001,
    RSBW_ADDR = 3'b010,
    RSBW_DATA = 3'b011,
    RSBW_ACK  = 3'b100,
    RSBW_SKIP = 3'b101
  } rsbw_state_t;

  // Current time as presented by the timekeeping counters
  typedef struct packed {
    logic [7:0] minutes;
    logic [7:0] hours;
    logic [7:0] date;
    logic [7:0] month;
  } rsbw_time_t;

  // Stamp date: tens 5-4, ones 3-0
  typedef struct packed {
    logic [1:0] pad;
    logic [1:0] day_tens_digit;
    logic [3:0] day_ones_digit;
  } rsbw_day_t;

  // Stamp month: weekday 7-5, month tens 4, month ones 3-0
  typedef struct packed {
    logic [2:0] weekday_code;
    logic       month_tens_digit;
    logic [3:0] month_ones_digit;
  } rsbw_month_t;
endpackage

// ==== design/rsbw_write_access.sv ====
// Two-wire target write path into timekeeper registers and backed SRAM
`timescale 1ns/10ps
`default_nettype none

module rsbw_write_access
(
  input  wire logic              i_clock,
  input  wire logic              i_rst,
  input  wire logic              i_scl,
  input  wire logic              i_sda,
  output logic                   o_sda_oe,
  output logic                   o_sda_out,
  input  wire logic              i_on_backup,
  input  wire rsbw_pkg::rsbw_time_t i_now,
  input  wire logic              i_osc_running,
  output logic [7:0]             o_pointer,
  output logic                   o_supply_loss_flag,
  output logic                   o_backup_input_enable,
  output rsbw_pkg::rsbw_day_t    o_dn_day,
  output rsbw_pkg::rsbw_month_t  o_dn_month,
  output rsbw_pkg::rsbw_day_t    o_up_day,
  output rsbw_pkg::rsbw_month_t  o_up_month,
  output logic                   o_wr_strobe,
  output logic [7:0]             o_wr_addr,
  output logic [7:0]             o_wr_data
);

  // Pin synchronisers
  logic [1:0] scl_sync_ff;
  logic [1:0] sda_sync_ff;
  logic [1:0] bkp_sync_ff;
  logic       scl_prev_ff;
  logic       sda_prev_ff;
  logic       bkp_prev_ff;

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      bkp_sync_ff <= 2'h0;
      scl_prev_ff <= 1'h1;
      sda_prev_ff <= 1'h1;
      bkp_prev_ff <= 1'h0;
    end
    else
    begin
      scl_sync_ff <= {scl_sync_ff[0], i_scl};
      sda_sync_ff <= {sda_sync_ff[0], i_sda};
      bkp_sync_ff <= {bkp_sync_ff[0], i_on_backup};
      scl_prev_ff <= scl_sync_ff[1];
      sda_prev_ff <= sda_sync_ff[1];
      bkp_prev_ff <= bkp_sync_ff[1];
    end
  end

  logic scl_s;
  logic sda_s;
  logic on_bkp;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  assign scl_s      = scl_sync_ff[1];
  assign sda_s      = sda_sync_ff[1];
  assign on_bkp     = bkp_sync_ff[1];
  assign scl_rise   = scl_s & ~scl_prev_ff;
  assign scl_fall   = ~scl_s & scl_prev_ff;
  assign start_cond = scl_s & scl_prev_ff & sda_prev_ff & ~sda_s;
  assign stop_cond  = scl_s & scl_prev_ff & ~sda_prev_ff & sda_s;

  // Bus engine
  rsbw_pkg::rsbw_state_t state_ff;
  rsbw_pkg::rsbw_state_t after_ack_ff;
  logic [7:0] shift_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] pointer_ff;
  logic       ack_ff;
  logic       ack_seen_ff;
  logic       wr_strobe_ff;
  logic [7:0] wr_addr_ff;
  logic [7:0] wr_data_ff;
  logic [7:0] nxt_pointer;
  logic [7:0] inc_pointer;
  logic       byte_done;

  assign byte_done = scl_rise &&
                     (bit_cnt_ff == rsbw_pkg::RSBW_BIT_LAST - 4'h1);

  always_comb
  begin
    inc_pointer = pointer_ff + 8'h01;
    if (pointer_ff == rsbw_pkg::RSBW_REG_LAST)
      inc_pointer = rsbw_pkg::RSBW_REG_FIRST;
    else if (pointer_ff == rsbw_pkg::RSBW_SRAM_LAST)
      inc_pointer = rsbw_pkg::RSBW_SRAM_FIRST;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst || on_bkp || start_cond || stop_cond)
    begin
      // Backup blocks the bus; start restarts the byte count
      state_ff    <= (start_cond && !on_bkp && !i_rst) ?
                     rsbw_pkg::RSBW_CTRL : rsbw_pkg::RSBW_IDLE;
      after_ack_ff <= rsbw_pkg::RSBW_IDLE;
      bit_cnt_ff  <= 4'h0;
      shift_ff    <= 8'h00;
      ack_ff      <= 1'b0;
      ack_seen_ff <= 1'b0;
    end
    else
    begin
      unique case (state_ff)
        rsbw_pkg::RSBW_IDLE: ;
        rsbw_pkg::RSBW_CTRL, rsbw_pkg::RSBW_ADDR, rsbw_pkg::RSBW_DATA,
        rsbw_pkg::RSBW_SKIP:
        begin
          if (scl_rise)
          begin
            shift_ff   <= {shift_ff[6:0], sda_s};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end
          if (byte_done)
          begin
            bit_cnt_ff <= 4'h0;
            unique case (state_ff)
              rsbw_pkg::RSBW_CTRL:
              begin
                // Reads and protected area are not served here
                if ({shift_ff[6:0], sda_s} ==
                    {rsbw_pkg::RSBW_CTRL_ADDR, 1'b0})
                begin
                  ack_ff       <= 1'b1;
                  after_ack_ff <= rsbw_pkg::RSBW_ADDR;
                  state_ff     <= rsbw_pkg::RSBW_ACK;
                end
                else
                  state_ff <= rsbw_pkg::RSBW_IDLE;
              end
              rsbw_pkg::RSBW_ADDR:
              begin
                if ({shift_ff[6:0], sda_s} > rsbw_pkg::RSBW_SRAM_LAST)
                begin
                  ack_ff       <= 1'b0;
                  after_ack_ff <= rsbw_pkg::RSBW_SKIP;
                end
                else
                begin
                  ack_ff       <= 1'b1;
                  after_ack_ff <= rsbw_pkg::RSBW_DATA;
                end
                state_ff <= rsbw_pkg::RSBW_ACK;
              end
              rsbw_pkg::RSBW_DATA:
              begin
                ack_ff       <= 1'b1;
                after_ack_ff <= rsbw_pkg::RSBW_DATA;
                state_ff     <= rsbw_pkg::RSBW_ACK;
              end
              default:
              begin
                ack_ff       <= 1'b0;
                after_ack_ff <= rsbw_pkg::RSBW_SKIP;
                state_ff     <= rsbw_pkg::RSBW_ACK;
              end
            endcase
          end
        end
        rsbw_pkg::RSBW_ACK:
        begin
          // Ack bit spans ninth clock; release after its falling edge
          if (scl_rise)
            ack_seen_ff <= 1'b1;
          if (scl_fall && ack_seen_ff)
          begin
            ack_ff      <= 1'b0;
            ack_seen_ff <= 1'b0;
            state_ff    <= after_ack_ff;
          end
        end
        default: state_ff <= rsbw_pkg::RSBW_IDLE;
      endcase
    end
  end

  // Pointer load and write strobe, taken at the last data bit
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      pointer_ff   <= rsbw_pkg::RSBW_REG_FIRST;
      wr_strobe_ff <= 1'b0;
      wr_addr_ff   <= 8'h00;
      wr_data_ff   <= 8'h00;
    end
    else
    begin
      wr_strobe_ff <= 1'b0;
      if (byte_done && !on_bkp && !start_cond && !stop_cond)
      begin
        if (state_ff == rsbw_pkg::RSBW_ADDR)
          pointer_ff <= {shift_ff[6:0], sda_s};
        else if (state_ff == rsbw_pkg::RSBW_DATA)
        begin
          wr_strobe_ff <= 1'b1;
          wr_addr_ff   <= pointer_ff;
          wr_data_ff   <= {shift_ff[6:0], sda_s};
          pointer_ff   <= inc_pointer;
        end
      end
    end
  end

  // SRAM: no reset, writes independent of timekeeping updates
  logic [7:0] sram_mem [0:63];
  always_ff @(posedge i_clock)
  begin
    if (wr_strobe_ff && wr_addr_ff >= rsbw_pkg::RSBW_SRAM_FIRST)
      sram_mem[wr_addr_ff[5:0]] <= wr_data_ff;
  end

  // Power flags and stamp registers
  logic       flag_ff;
  logic       vben_ff;
  logic [7:0] stamp_ff [0:7];
  logic       reg_wr;
  logic       loss_evt;
  logic       return_evt;
  logic [2:0] sidx;
  logic [7:0] smask;
  logic [7:0] weekday_code_byte;
  logic       up_pend_ff;
  logic       stamp_clr;
  logic       dn_log;
  logic       up_log;

  assign reg_wr     = wr_strobe_ff && (wr_addr_ff <= rsbw_pkg::RSBW_REG_LAST);
  assign loss_evt   = on_bkp & ~bkp_prev_ff;
  assign return_evt = ~on_bkp & bkp_prev_ff;
  assign sidx       = wr_addr_ff[2:0];
  assign weekday_code_byte = {2'b00, i_osc_running, flag_ff, vben_ff, 3'b000};
  assign stamp_clr  = reg_wr && wr_addr_ff == rsbw_pkg::RSBW_WEEKDAY_CODE_ADDR &&
                      !wr_data_ff[rsbw_pkg::RSBW_FLAG_BIT];
  assign dn_log     = loss_evt && vben_ff && !flag_ff;
  assign up_log     = return_evt && up_pend_ff;

  // Return stamp belongs to the loss that set the flag
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      up_pend_ff <= 1'b0;
    else if (dn_log)
      up_pend_ff <= 1'b1;
    else if (up_log || stamp_clr)
      up_pend_ff <= 1'b0;
  end

  always_comb
  begin
    unique case (sidx[1:0])
      2'b00:   smask = rsbw_pkg::RSBW_MIN_MASK;
      2'b01:   smask = rsbw_pkg::RSBW_HOUR_MASK;
      2'b10:   smask = rsbw_pkg::RSBW_DATE_MASK;
      default: smask = rsbw_pkg::RSBW_MONTH_MASK;
    endcase
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      flag_ff <= 1'b0;
      vben_ff <= 1'b0;
    end
    else if (dn_log)
      flag_ff <= 1'b1;
    else if (reg_wr && wr_addr_ff == rsbw_pkg::RSBW_WEEKDAY_CODE_ADDR)
    begin
      flag_ff <= flag_ff & wr_data_ff[rsbw_pkg::RSBW_FLAG_BIT];
      vben_ff <= wr_data_ff[rsbw_pkg::RSBW_VBEN_BIT];
    end
  end

  always_ff @(posedge i_clock)
  begin
    // Logging wins over a clear in the same cycle
    if (i_rst || (stamp_clr && !dn_log && !up_log))
    begin
      for (int k = 0; k < 8; k++)
        stamp_ff[k] <= rsbw_pkg::RSBW_STAMP_RST;
    end
    else if (dn_log || up_log)
    begin
      // Lower set for power-down, upper for power-up
      stamp_ff[{up_log, 2'b00}] <= i_now.minutes & rsbw_pkg::RSBW_MIN_MASK;
      stamp_ff[{up_log, 2'b01}] <= i_now.hours & rsbw_pkg::RSBW_HOUR_MASK;
      stamp_ff[{up_log, 2'b10}] <= i_now.date & rsbw_pkg::RSBW_DATE_MASK;
      stamp_ff[{up_log, 2'b11}] <= i_now.month;
    end
    else if (reg_wr && wr_addr_ff >= rsbw_pkg::RSBW_DN_MIN)
      stamp_ff[sidx] <= wr_data_ff & smask;
  end

  // Outputs
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      o_sda_oe              <= 1'b0;
      o_sda_out             <= 1'b0;
      o_pointer             <= 8'h00;
      o_supply_loss_flag    <= 1'b0;
      o_backup_input_enable <= 1'b0;
      o_dn_day              <= '0;
      o_dn_month            <= '0;
      o_up_day              <= '0;
      o_up_month            <= '0;
      o_wr_strobe           <= 1'b0;
      o_wr_addr             <= 8'h00;
      o_wr_data             <= 8'h00;
    end
    else
    begin
      // Open drain: enable only pulls low
      // Pull only once SCL is low: a pull while the eighth bit is
      // still high would look like a start condition
      o_sda_oe              <= ack_ff && state_ff == rsbw_pkg::RSBW_ACK &&
                               (ack_seen_ff || scl_rise || !scl_s) &&
                               !on_bkp;
      o_sda_out             <= 1'b0;
      o_pointer             <= pointer_ff;
      o_supply_loss_flag    <= weekday_code_byte[rsbw_pkg::RSBW_FLAG_BIT];
      o_backup_input_enable <= weekday_code_byte[rsbw_pkg::RSBW_VBEN_BIT];
      o_dn_day              <= stamp_ff[3'h2];
      o_dn_month            <= stamp_ff[3'h3];
      o_up_day              <= stamp_ff[3'h6];
      o_up_month            <= stamp_ff[3'h7];
      o_wr_strobe           <= wr_strobe_ff;
      o_wr_addr             <= wr_addr_ff;
      o_wr_data             <= wr_data_ff;
    end
  end

endmodule // rsbw_write_access

`default_nettype wire

// ==== bench/rsbw_sva.sv ====
// Checker of port relations for the bus write path
`timescale 1ns/10ps
`default_nettype none

module rsbw_sva
(
  input wire logic                  i_clock,
  input wire logic                  i_rst,
  input wire logic                  i_on_backup,
  input wire rsbw_pkg::rsbw_time_t  i_now,
  input wire logic                  o_sda_oe,
  input wire logic [7:0]            o_pointer,
  input wire logic                  o_supply_loss_flag,
  input wire rsbw_pkg::rsbw_day_t   o_dn_day,
  input wire rsbw_pkg::rsbw_month_t o_dn_month,
  input wire rsbw_pkg::rsbw_day_t   o_up_day,
  input wire rsbw_pkg::rsbw_month_t o_up_month,
  input wire logic                  o_wr_strobe,
  input wire logic [7:0]            o_wr_addr,
  input wire logic [7:0]            o_wr_data
);
  logic [7:0] wrap_addr;
  logic       stamps_zero;

  always_comb
  begin
    wrap_addr = o_wr_addr + 8'h01;
    if (o_wr_addr == rsbw_pkg::RSBW_REG_LAST)
      wrap_addr = rsbw_pkg::RSBW_REG_FIRST;
    if (o_wr_addr == rsbw_pkg::RSBW_SRAM_LAST)
      wrap_addr = rsbw_pkg::RSBW_SRAM_FIRST;
  end
  assign stamps_zero = ({o_dn_day, o_dn_month, o_up_day, o_up_month}
                        == 32'h00000000);

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  AST_ACK_HOLD: assert property ($rose(o_sda_oe) |-> o_sda_oe [*8])
    else $error("ack released too early");
  AST_BACKUP_QUIET: assert property (
    i_on_backup [*5] |-> !o_sda_oe && !o_wr_strobe)
    else $error("bus active on backup supply");
  AST_WR_RANGE: assert property (
    o_wr_strobe |-> o_wr_addr <= rsbw_pkg::RSBW_SRAM_LAST)
    else $error("write beyond top of memory");
  AST_PTR_STEP: assert property (
    o_wr_strobe |-> ##[0:2] o_pointer == wrap_addr)
    else $error("pointer did not step past write");
  AST_STROBE_PULSE: assert property (o_wr_strobe |=> !o_wr_strobe)
    else $error("write strobe longer than one cycle");
  AST_WR_HOLD: assert property (
    !o_wr_strobe |-> $stable(o_wr_addr) && $stable(o_wr_data))
    else $error("write bus moved without strobe");
  AST_DAY_PAD: assert property (
    o_dn_day.pad == 2'b00 && o_up_day.pad == 2'b00)
    else $error("unimplemented day bits set");
  AST_FLAG_CLEAR: assert property (
    $fell(o_supply_loss_flag) |-> ##[0:2] stamps_zero)
    else $error("stamps kept after flag clear");
  AST_STAMP_LOG: assert property (
    $rose(o_supply_loss_flag) |-> ##[0:2]
      (o_dn_month == i_now.month || o_up_month == i_now.month))
    else $error("flag set without stamp");

  cover property (o_wr_strobe && o_wr_addr == 8'h5f);
  cover property (o_wr_strobe && o_wr_addr == 8'h1f);
  cover property ($rose(o_supply_loss_flag));
  cover property ($fell(o_supply_loss_flag));
endmodule // rsbw_sva

bind rsbw_write_access rsbw_sva u_sva
(
  .i_clock(i_clock), .i_rst(i_rst), .i_on_backup(i_on_backup),
  .i_now(i_now), .o_sda_oe(o_sda_oe), .o_pointer(o_pointer),
  .o_supply_loss_flag(o_supply_loss_flag), .o_dn_day(o_dn_day),
  .o_dn_month(o_dn_month), .o_up_day(o_up_day),
  .o_up_month(o_up_month), .o_wr_strobe(o_wr_strobe),
  .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data)
);

`default_nettype wire

// ==== bench/rsbw_master.sv ====
// Partner model: two-wire bus controller, open-drain data line
`timescale 1ns/10ps
`default_nettype none

module rsbw_master
(
  input  wire logic i_clock,
  input  wire logic i_sda_oe,
  output var logic  o_scl,
  output wire logic o_sda
);
  logic drive_low;

  // Pull-up: line high unless some party pulls it
  assign o_sda = !(drive_low || i_sda_oe);

  initial
  begin
    o_scl = 1'b1;
    drive_low = 1'b0;
  end

  // Quarter of the 160 ns link period
  task automatic q(input int n);
    repeat (4 * n) @(negedge i_clock);
  endtask

  task automatic start();
    drive_low = 1'b1;
    q(2);
    o_scl = 1'b0;
    q(1);
  endtask

  // Data moves a quarter after the clock falls, clear of sync lag
  task automatic put(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      drive_low = !b[i];
      q(1);
      o_scl = 1'b1;
      q(2);
      o_scl = 1'b0;
      q(1);
    end
    drive_low = 1'b0;
    q(1);
    o_scl = 1'b1;
    q(1);
    ack = (o_sda === 1'b0);
    q(1);
    o_scl = 1'b0;
    q(1);
  endtask

  task automatic stop();
    drive_low = 1'b1;
    q(1);
    o_scl = 1'b1;
    q(2);
    drive_low = 1'b0;
    q(2);
  endtask
endmodule // rsbw_master

`default_nettype wire

// ==== bench/test_rsbw_write_access.sv ====
// Testbench for the bus write path
`timescale 1ns/10ps
`default_nettype none

module test_rsbw_write_access;
  logic                  i_clock, i_rst, i_on_backup, scl, sda;
  logic                  sda_oe, flag, stb, ok, vben;
  logic [7:0]            ptr, w_addr, w_data, a, d, e;
  logic [2:0]            ak;
  logic                  k;
  rsbw_pkg::rsbw_time_t  now = '{8'h45, 8'h12, 8'h31, 8'h52};
  rsbw_pkg::rsbw_day_t   dn_day, up_day;
  rsbw_pkg::rsbw_month_t dn_mon, up_mon;
  int                    bad_count, n_tests, n_wr, base;
  logic [16:0] rows [7] = '{{1'b1, 8'h20, 8'ha5}, {1'b1, 8'h5f, 8'h3c},
    {1'b1, 8'h00, 8'h11}, {1'b1, 8'h1b, 8'hd5}, {1'b1, 8'h1a, 8'hff},
    {1'b0, 8'h60, 8'h77}, {1'b0, 8'hff, 8'h01}};

  rsbw_write_access dut
  (
    .i_clock(i_clock), .i_rst(i_rst), .i_scl(scl), .i_sda(sda),
    .o_sda_oe(sda_oe), .o_sda_out(), .i_on_backup(i_on_backup),
    .i_now(now), .i_osc_running(1'b1), .o_pointer(ptr),
    .o_supply_loss_flag(flag), .o_backup_input_enable(vben),
    .o_dn_day(dn_day), .o_dn_month(dn_mon), .o_up_day(up_day),
    .o_up_month(up_mon), .o_wr_strobe(stb), .o_wr_addr(w_addr),
    .o_wr_data(w_data)
  );

  rsbw_master m
  (
    .i_clock(i_clock), .i_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda)
  );

  always @(negedge i_clock)
    if (stb === 1'b1)
      n_wr++;

  function automatic logic [7:0] wrap(input logic [7:0] x);
    return x == 8'h1f ? 8'h00 : x == 8'h5f ? 8'h20 : x + 8'h01;
  endfunction

  task automatic chk(input logic [7:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] wa, wd, input int n);
    logic r;
    m.start();
    m.put(8'hde, ak[2]);
    m.put(wa, ak[1]);
    ak[0] = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      m.put(wd + 8'(i), r);
      ak[0] &= r;
    end
    m.stop();
  endtask

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  // Hang guard
  initial
  begin
    repeat (100000) @(posedge i_clock);
    bad_count++;
    $display("MISMATCH at %0t: run too long", $time);
    print_verdict();
  end

  initial
  begin
    i_rst = 1'b1;
    i_on_backup = 1'b0;
    repeat (4) @(negedge i_clock);
    i_rst = 1'b0;
    repeat (5) @(negedge i_clock);
    chk(ptr, 8'h00);
    chk(dn_day, 8'h00);
    chk(dn_mon, 8'h00);
    chk(up_day, 8'h00);
    chk(up_mon, 8'h00);
    $display("Test reset done");
    foreach (rows[r])
    begin
      {ok, a, d} = rows[r];
      base = n_wr;
      wr(a, d, 1);
      chk(8'(ak), ok ? 8'h07 : 8'h04);
      chk(ptr, ok ? wrap(a) : a);
      chk(8'(n_wr - base), 8'(ok));
      if (ok)
        chk(w_data, d);
    end
    chk(dn_day, 8'h3f);
    chk(dn_mon, 8'hd5);
    $display("Test byte writes done");
    for (int s = 0; s < 2; s++)
    begin
      a = s ? 8'h1f : 8'h5e;
      base = n_wr;
      wr(a, 8'h90, 3);
      e = wrap(wrap(a));
      chk(8'(ak), 8'h07);
      chk(8'(n_wr - base), 8'h03);
      chk(w_addr, e);
      chk(w_data, 8'h92);
      chk(ptr, wrap(e));
    end
    $display("Test sequential done");
    for (int c = 0; c < 3; c++)
    begin
      m.start();
      m.put(c == 0 ? 8'hae : c == 1 ? 8'hdf : 8'haf, k);
      m.stop();
      chk(8'(k), 8'h00);
    end
    $display("Test foreign control done");
    wr(8'h03, 8'h08, 1);
    chk(8'(vben), 8'h01);
    i_on_backup = 1'b1;
    for (int i = 0; i < 50 && flag !== 1'b1; i++) @(negedge i_clock);
    chk(8'(flag), 8'h01);
    chk(dn_day, now.date & rsbw_pkg::RSBW_DATE_MASK);
    chk(dn_mon, now.month);
    base = n_wr;
    wr(8'h20, 8'h55, 1);
    chk(8'(ak), 8'h00);
    chk(8'(n_wr - base), 8'h00);
    i_on_backup = 1'b0;
    repeat (10) @(negedge i_clock);
    chk(up_day, now.date & rsbw_pkg::RSBW_DATE_MASK);
    chk(up_mon, now.month);
    wr(8'h03, 8'h08, 1);
    for (int i = 0; i < 50 && flag !== 1'b0; i++) @(negedge i_clock);
    chk(8'(flag), 8'h00);
    chk(dn_mon, 8'h00);
    chk(up_mon, 8'h00);
    $display("Test backup done");
    print_verdict();
  end
endmodule // test_rsbw_write_access

`default_nettype wire
